// File: core/hpdc_pkg.sv
// shared constants and carrier types of the hall period and duty control block
package hpdc_pkg;
    // register indices on the serial register port
    localparam logic [7:0] ADDR_CONTROL  = 8'h00;  // control_register
    localparam logic [7:0] ADDR_DUTY     = 8'h01;  // duty_setting
    localparam logic [7:0] ADDR_PER_HIGH = 8'h02;  // hall_period_high
    localparam logic [7:0] ADDR_PER_LOW  = 8'h03;  // hall_period_low
    // control register fields
    localparam int          CTRL_DSEL_BIT   = 0;     // duty_source_select
    localparam int          CTRL_RANGE_LSB  = 1;     // hall_range_select low bit
    localparam logic [7:0]  CTRL_RESET      = 8'h00; // control reset value
    localparam logic [7:0]  DUTY_RESET      = 8'h00; // duty_setting reset value
    // hall range select codes
    localparam logic [1:0]  RANGE_SYS       = 2'h0;  // count at system clock
    localparam logic [1:0]  RANGE_DOUBLE    = 2'h1;  // count at twice system clock
    // pwm counter runs 0..PWM_LAST, giving 255 equal duty steps
    localparam logic [7:0]  PWM_LAST        = 8'hFE;
    localparam logic [7:0]  DUTY_FULL       = 8'hFF;
    localparam logic [7:0]  DUTY_MIN        = 8'h04; // duty during cycle limiting
    // short circuit: consecutive pwm pulses over the level before trip
    localparam logic [1:0]  SC_PULSES       = 2'h3;
    // overload timer: charge and discharge steps, trip level
    localparam logic [13:0] OL_CHARGE       = 14'h0004;
    localparam logic [13:0] OL_DISCHARGE    = 14'h0001;
    localparam logic [13:0] OL_TRIP         = 14'h3E80;
    localparam logic [15:0] PERIOD_MAX      = 16'hFFFF;

    // register port request
    typedef struct packed {
        logic       wr;     // write strobe
        logic       rd;     // read strobe
        logic [7:0] addr;   // register index
        logic [7:0] wdata;  // write data
    } hpdc_req_type;

    // analog comparator results
    typedef struct packed {
        logic over_torque;  // current feedback above torque reference
        logic overload;     // current sense above overload level
        logic cycle;        // current sense above cycle limit level
        logic short_c;      // current sense above short circuit level
    } hpdc_cmp_type;

    // protection latch state, one-hot
    typedef enum logic [2:0] {
        HPDC_RUN  = 3'b001,
        HPDC_TRIP = 3'b010,
        HPDC_FREE = 3'b100
    } hpdc_trip_type;
endpackage : hpdc_pkg

// File: core/hpdc_period.sv
// hall change period counter with selectable count rate and freeze
`timescale 1ns/100ps
module hpdc_period (
    input  wire logic        ref_clk,     // system clock
    input  wire logic        nrst,        // async reset, active low
    input  wire logic [2:0]  hall,        // hall sensor levels
    input  wire logic [1:0]  range_sel,   // hall_range_select
    input  wire logic        freeze,      // hold period, clear running count
    output logic      [15:0] period,      // last measured period
    output logic             hall_change  // one-cycle pulse per hall edge
);
    typedef struct packed {
        logic        primed;   // first hall sample taken
        logic [2:0]  hall_q;   // previous hall sample
        logic [1:0]  div;      // prescaler for slow range
        logic [15:0] cnt;      // running interval count
        logic [15:0] per;      // captured period
    } hpdc_per_state_type;

    hpdc_per_state_type s_r;    // registered state
    hpdc_per_state_type s_nxt;  // next state
    logic               chg;    // hall edge seen
    logic [15:0]        step;   // count increment this cycle
    logic [16:0]        sum;    // widened sum for saturation

    // count step per cycle from the range select
    always_comb begin
        chg = s_r.primed && (hall != s_r.hall_q);
        if (range_sel == hpdc_pkg::RANGE_SYS) begin
            step = 16'h0001;
        end else if (range_sel == hpdc_pkg::RANGE_DOUBLE) begin
            step = 16'h0002;
        end else begin
            step = (s_r.div == 2'h3) ? 16'h0001 : 16'h0000;
        end
        sum = {1'b0, s_r.cnt} + {1'b0, step};
    end

    // next state: measure, capture on hall edge, hold period and clear count while frozen
    always_comb begin
        s_nxt        = s_r;
        s_nxt.primed = 1'b1;
        s_nxt.hall_q = hall;
        s_nxt.div    = s_r.div + 2'h1;
        if (freeze) begin
            s_nxt.cnt = 16'h0000;
        end else if (chg) begin
            s_nxt.per = s_r.cnt;
            s_nxt.cnt = 16'h0000;
        end else if (sum[16]) begin
            s_nxt.cnt = hpdc_pkg::PERIOD_MAX;
        end else begin
            s_nxt.cnt = sum[15:0];
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign period      = s_r.per;
    assign hall_change = chg;

    a_period_sat: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_r.cnt == 16'hFFFF && !chg && !freeze) |=> s_r.cnt == 16'hFFFF)
        else $error("period counter wrapped");
    a_range_div4: assert property (@(posedge ref_clk) disable iff (!nrst)
        (range_sel[1] && !freeze && !chg && s_r.div != 2'h3 && s_r.cnt != 16'hFFFF)
        |=> s_r.cnt == $past(s_r.cnt))
        else $error("slow range counted too fast");
endmodule : hpdc_period

// File: core/hpdc_core.sv
// duty selection, protections, speed toggle and period registers
//
// Functional notes
// - control bit selects register duty in serial mode
// - duty setting register is eight bits read/write
// - register value zero gives zero duty
// - all ones full duty, linear 255 steps
// - sixteen-bit hall change period, high/low bytes
// - range select picks the period count rate
// - high byte read freezes both period bytes
// - measuring resumes only after low byte read
// - speed output toggles on every hall change
// - over-torque lowers duty progressively, else follow source (ceiling climbs back one step per pwm period)
// - overload, cycle limit, short circuit stages
// - cycle limit forces minimum duty at once
// - short circuit pulses latch drives off until free/start
`timescale 1ns/100ps
module hpdc_core (
    input  wire logic                  ref_clk,             // 40 MHz system clock
    input  wire logic                  nrst,                // async reset, active low
    input  wire logic                  serial_mode,         // serial register mode active
    input  wire hpdc_pkg::hpdc_req_type req,                // register port request
    output logic                       reg_rvalid,          // read data valid pulse
    output logic [7:0]                 reg_rdata,           // read data
    input  wire logic [7:0]            duty_pin_code,       // converted duty pin level
    input  wire logic [2:0]            hall,                // hall sensor levels
    input  wire hpdc_pkg::hpdc_cmp_type cmp,                // comparator results
    input  wire logic                  free_start_input,    // high free, low start
    output logic                       speed_toggle_output, // toggles per hall change
    output logic [7:0]                 duty_out,            // applied pwm duty
    output logic                       pwm_out,             // pwm pulse
    output logic                       drive_enable         // low turns all six drives off
);
    typedef struct packed {
        logic [7:0]              ctrl;       // control_register
        logic [7:0]              duty_reg;   // duty_setting
        logic [7:0]              rdata;      // read data
        logic                    rvalid;     // read answer
        logic                    frozen;     // period bytes frozen
        logic                    spd;        // speed toggle level
        logic [7:0]              pwm_cnt;    // pwm phase counter
        logic [7:0]              duty;       // applied duty
        logic                    pwm;        // pwm output
        logic [7:0]              tq_lim;     // torque duty ceiling
        logic                    sc_hit;     // short level seen this period
        logic [1:0]              sc_cnt;     // consecutive short periods
        logic [13:0]             ol_lvl;     // overload timer level
        hpdc_pkg::hpdc_trip_type trip;       // protection latch
    } hpdc_core_state_type;

    hpdc_core_state_type s_r;         // registered state
    hpdc_core_state_type s_nxt;       // next state
    logic [15:0]         period;      // measured period
    logic                hall_change; // hall edge pulse
    logic                rd_high;     // read of period high byte
    logic                rd_low;      // read of period low byte
    logic                freeze_now;  // freeze including this cycle's read
    logic [7:0]          src_duty;    // speed loop duty source
    logic [7:0]          lim_duty;    // after torque ceiling
    logic                per_end;     // last cycle of pwm period
    logic                sc_now;      // short level in ending period
    logic                ol_trip;     // overload timer expired

    // true when a read strobe hits the given register index
    function automatic logic rd_hit(input hpdc_pkg::hpdc_req_type r, input logic [7:0] a);
        rd_hit = r.rd && (r.addr == a);
    endfunction : rd_hit

    always_comb begin
        rd_high    = rd_hit(req, hpdc_pkg::ADDR_PER_HIGH);
        rd_low     = rd_hit(req, hpdc_pkg::ADDR_PER_LOW);
        freeze_now = s_r.frozen || rd_high;
    end

    // period measurement
    hpdc_period u_period (
        .ref_clk     (ref_clk),
        .nrst        (nrst),
        .hall        (hall),
        .range_sel   (s_r.ctrl[hpdc_pkg::CTRL_RANGE_LSB +: 2]),
        .freeze      (freeze_now),
        .period      (period),
        .hall_change (hall_change)
    );

    // duty path and protection decisions
    always_comb begin
        // pick register or pin duty
        if (serial_mode && s_r.ctrl[hpdc_pkg::CTRL_DSEL_BIT]) begin
            src_duty = s_r.duty_reg;
        end else begin
            src_duty = duty_pin_code;
        end
        // torque ceiling limits the speed loop duty
        lim_duty = (src_duty < s_r.tq_lim) ? src_duty : s_r.tq_lim;
        per_end  = (s_r.pwm_cnt == hpdc_pkg::PWM_LAST);
        sc_now   = s_r.sc_hit || cmp.short_c;
        ol_trip  = (s_r.ol_lvl >= hpdc_pkg::OL_TRIP);
    end

    // next state
    always_comb begin
        s_nxt        = s_r;
        s_nxt.rvalid = req.rd;
        // register writes
        if (req.wr && req.addr == hpdc_pkg::ADDR_CONTROL) begin
            s_nxt.ctrl = req.wdata;
        end
        if (req.wr && req.addr == hpdc_pkg::ADDR_DUTY) begin
            s_nxt.duty_reg = req.wdata;
        end
        // register reads, unmapped indices answer zero
        if (req.rd) begin
            unique case (req.addr)
                hpdc_pkg::ADDR_CONTROL:  s_nxt.rdata = s_r.ctrl;
                hpdc_pkg::ADDR_DUTY:     s_nxt.rdata = s_r.duty_reg;
                hpdc_pkg::ADDR_PER_HIGH: s_nxt.rdata = period[15:8];
                hpdc_pkg::ADDR_PER_LOW:  s_nxt.rdata = period[7:0];
                default:                 s_nxt.rdata = 8'h00;
            endcase
        end
        // freeze on high read, release on low read; low first is harmless
        if (rd_high) begin
            s_nxt.frozen = 1'b1;
        end else if (rd_low) begin
            s_nxt.frozen = 1'b0;
        end
        // speed output
        if (hall_change) begin
            s_nxt.spd = !s_r.spd;
        end
        // pwm phase and output; duty compares against 0..254
        s_nxt.pwm_cnt = per_end ? 8'h00 : s_r.pwm_cnt + 8'h01;
        s_nxt.pwm     = (s_r.trip == hpdc_pkg::HPDC_RUN) && (s_r.duty > s_r.pwm_cnt);
        // applied duty, cycle limit overrides at once
        s_nxt.duty = cmp.cycle ? hpdc_pkg::DUTY_MIN : lim_duty;
        // torque ceiling moves one step per pwm period
        if (per_end) begin
            if (cmp.over_torque && s_r.tq_lim != 8'h00) begin
                s_nxt.tq_lim = s_r.tq_lim - 8'h01;
            end else if (!cmp.over_torque && s_r.tq_lim != hpdc_pkg::DUTY_FULL) begin
                s_nxt.tq_lim = s_r.tq_lim + 8'h01;
            end
        end
        // short circuit pulse counting per pwm period
        if (per_end) begin
            s_nxt.sc_hit = 1'b0;
            if (!sc_now) begin
                s_nxt.sc_cnt = 2'h0;
            end else if (s_r.sc_cnt != hpdc_pkg::SC_PULSES) begin
                s_nxt.sc_cnt = s_r.sc_cnt + 2'h1;
            end
        end else begin
            s_nxt.sc_hit = sc_now;
        end
        // overload timer charges fast, discharges slowly
        if (cmp.overload) begin
            s_nxt.ol_lvl = ol_trip ? s_r.ol_lvl : s_r.ol_lvl + hpdc_pkg::OL_CHARGE;
        end else if (s_r.ol_lvl >= hpdc_pkg::OL_DISCHARGE) begin
            s_nxt.ol_lvl = s_r.ol_lvl - hpdc_pkg::OL_DISCHARGE;
        end
        // protection latch
        unique case (s_r.trip)
            hpdc_pkg::HPDC_RUN: begin
                if (s_r.sc_cnt == hpdc_pkg::SC_PULSES || ol_trip) begin
                    s_nxt.trip = hpdc_pkg::HPDC_TRIP;
                end
            end
            hpdc_pkg::HPDC_TRIP: begin
                if (free_start_input) begin
                    s_nxt.trip = hpdc_pkg::HPDC_FREE;
                end
            end
            hpdc_pkg::HPDC_FREE: begin
                if (!free_start_input) begin
                    s_nxt.trip   = hpdc_pkg::HPDC_RUN;
                    s_nxt.sc_cnt = 2'h0;
                    s_nxt.ol_lvl = 14'h0000;
                end
            end
            default: begin
                s_nxt.trip = hpdc_pkg::HPDC_TRIP;  // illegal code latches off
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_r          <= '0;
            s_r.ctrl     <= hpdc_pkg::CTRL_RESET;
            s_r.duty_reg <= hpdc_pkg::DUTY_RESET;
            s_r.tq_lim   <= hpdc_pkg::DUTY_FULL;
            s_r.trip     <= hpdc_pkg::HPDC_RUN;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs
    assign reg_rvalid          = s_r.rvalid;
    assign reg_rdata           = s_r.rdata;
    assign speed_toggle_output = s_r.spd;
    assign duty_out            = s_r.duty;
    assign pwm_out             = s_r.pwm;
    assign drive_enable        = (s_r.trip == hpdc_pkg::HPDC_RUN);

    a_duty_source: assert property (@(posedge ref_clk) disable iff (!nrst)
        (serial_mode && s_r.ctrl[0] && !cmp.cycle && s_r.tq_lim == 8'hFF)
        |=> duty_out == $past(s_r.duty_reg))
        else $error("register duty not applied");
    a_duty_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
        (duty_out == 8'h00) |=> !pwm_out)
        else $error("zero duty produced a pulse");
    a_duty_full: assert property (@(posedge ref_clk) disable iff (!nrst)
        (duty_out == 8'hFF && drive_enable) |=> pwm_out)
        else $error("full duty dropped the pulse");
    a_freeze_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        (rd_high || s_r.frozen) |=> period == $past(period))
        else $error("period changed while frozen");
    a_low_release: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_r.frozen && rd_low) |=> !s_r.frozen ##1 (!s_r.frozen || $past(rd_high)))
        else $error("low read did not release freeze");
    a_speed_toggle: assert property (@(posedge ref_clk) disable iff (!nrst)
        hall_change |=> speed_toggle_output != $past(speed_toggle_output))
        else $error("speed output missed a hall change");
    a_torque_step: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cmp.over_torque && per_end && s_r.tq_lim != 8'h00)
        |=> s_r.tq_lim == $past(s_r.tq_lim) - 8'h01)
        else $error("torque ceiling did not step down");
    a_cycle_min: assert property (@(posedge ref_clk) disable iff (!nrst)
        cmp.cycle |=> duty_out == 8'h04)
        else $error("cycle limit did not force minimum duty");
    a_trip_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_r.trip == hpdc_pkg::HPDC_TRIP && !free_start_input)
        |=> !drive_enable && !pwm_out)
        else $error("drives came back without free/start cycle");
    a_short_count: assert property (@(posedge ref_clk) disable iff (!nrst)
        (drive_enable && s_r.sc_cnt == 2'h3) |=> !drive_enable)
        else $error("short circuit count did not trip");

    c_freeze_read: cover property (@(posedge ref_clk) disable iff (!nrst)
        rd_high ##[1:20] rd_low);
    c_short_trip: cover property (@(posedge ref_clk) disable iff (!nrst)
        $fell(drive_enable) && s_r.trip == hpdc_pkg::HPDC_TRIP);
    c_restart: cover property (@(posedge ref_clk) disable iff (!nrst)
        $rose(drive_enable));
    c_torque_low: cover property (@(posedge ref_clk) disable iff (!nrst)
        s_r.tq_lim == 8'h80);
endmodule : hpdc_core

// File: tb/hpdc_host_model.sv
// host model that reaches the duty control block over its register port
`timescale 1ns/100ps
module hpdc_host_model (
    input  wire logic              ref_clk,    // system clock
    output hpdc_pkg::hpdc_req_type req,        // register request to the block
    input  wire logic              reg_rvalid, // read data valid pulse
    input  wire logic [7:0]        reg_rdata   // read data
);
    // strobes low at time zero, bus fields parked
    initial begin
        req = 18'h00000;
    end

    // released bus shows the inverse of its last value, never a stale copy
    task automatic park;
        req.wr    = 1'b0;
        req.rd    = 1'b0;
        req.addr  = ~req.addr;
        req.wdata = ~req.wdata;
    endtask : park

    // one-cycle write strobe, taken at the next rising edge
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        req.wr    = 1'b1;
        req.addr  = a;
        req.wdata = d;
        @(negedge ref_clk);
        park();
    endtask : write_reg

    // one-cycle read strobe, then a bounded wait for the valid pulse;
    // the pulse stands in the cycle right after the strobe edge, so look there first
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output bit ok);
        @(negedge ref_clk);
        req.rd   = 1'b1;
        req.addr = a;
        @(negedge ref_clk);
        park();
        ok = 1'b0;
        d  = 8'h00;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (reg_rvalid === 1'b1) begin
                d  = reg_rdata;
                ok = 1'b1;
            end else begin
                @(negedge ref_clk);
            end
        end
    endtask : read_reg
endmodule : hpdc_host_model

// File: tb/hall_period_duty_control_tb_top.sv
// self-checking bench of the hall period and duty control block
`timescale 1ns/100ps
module hall_period_duty_control_tb_top;
    logic                   ref_clk;     // 40 MHz clock
    logic                   nrst;        // reset, active low
    logic                   serial_mode; // serial register mode
    hpdc_pkg::hpdc_req_type req;         // request from the host model
    logic                   reg_rvalid;  // read valid
    logic [7:0]             reg_rdata;   // read data
    logic [7:0]             duty_pin;    // converted duty pin level
    logic [2:0]             hall;        // hall levels
    hpdc_pkg::hpdc_cmp_type cmp;         // comparator levels
    logic                   free_start;  // free/start level
    logic                   speed;       // speed toggle output
    logic [7:0]             duty_out;    // applied duty
    logic                   pwm_out;     // pwm pulse
    logic                   drive_en;    // drive enable
    int                     n_mismatch;  // mismatches seen
    int                     tests_run;   // comparisons made
    int                     hidx;        // hall table position
    logic [2:0]             hall_tab [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    logic [7:0]             duty_tab [3] = '{8'h00, 8'h80, 8'hFF};
    logic [7:0]             d;           // scratch read data
    logic [15:0]            v;           // scratch period
    logic                   s;           // speed before a change
    int                     n;           // pwm high count

    hpdc_core DUT (.ref_clk(ref_clk), .nrst(nrst), .serial_mode(serial_mode), .req(req),
        .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata), .duty_pin_code(duty_pin), .hall(hall),
        .cmp(cmp), .free_start_input(free_start), .speed_toggle_output(speed),
        .duty_out(duty_out), .pwm_out(pwm_out), .drive_enable(drive_en));
    hpdc_host_model host (.ref_clk(ref_clk), .req(req), .reg_rvalid(reg_rvalid),
        .reg_rdata(reg_rdata));

    // free-running clock, 25 ns period
    always #12.5 ref_clk = ~ref_clk;

    // counts and prints the verdict, then ends the run
    task automatic give_verdict;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    // compares seen against expected and reports a difference at once
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one when the period lies within two counts of the expectation
    function automatic logic [15:0] near(input logic [15:0] a, input logic [15:0] e);
        logic [16:0] dd;
        dd = {1'b0, a} - {1'b0, e} + 17'h00002;
        return {15'h0000, dd <= 17'h00004};
    endfunction : near

    task automatic tick(input int c);
        repeat (c) @(negedge ref_clk);
    endtask : tick

    // register read; a lost valid pulse counts as a mismatch and ends the run
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        bit ok;
        host.read_reg(a, q, ok);
        if (!ok) begin
            n_mismatch++;
            give_verdict();
        end
    endtask : rd

    // period read, high byte first so both bytes come from one frozen value
    task automatic period_rd(output logic [15:0] p);
        rd(hpdc_pkg::ADDR_PER_HIGH, p[15:8]);
        rd(hpdc_pkg::ADDR_PER_LOW, p[7:0]);
    endtask : period_rd

    // next hall pattern, one sensor changes
    task automatic hall_step;
        hidx = (hidx + 1) % 6;
        hall = hall_tab[hidx];
    endtask : hall_step

    // counts pwm high cycles over one full pwm period
    task automatic pwm_high(output int c);
        c = 0;
        repeat (255) begin
            @(negedge ref_clk);
            c += (pwm_out === 1'b1) ? 1 : 0;
        end
    endtask : pwm_high

    // holds one comparator, then walks the latch through free and start
    task automatic trip(input int bitpos, input int cycles);
        cmp[bitpos] = 1'b1;
        tick(cycles);
        cmp[bitpos] = 1'b0;
        tick(2);
        check("drive off", drive_en, 16'h0000);
        pwm_high(n);
        check("pwm latched", n[15:0], 16'h0000);
        free_start = 1'b1;
        tick(3);
        check("drive in free", drive_en, 16'h0000);
        free_start = 1'b0;
        tick(3);
        check("drive restart", drive_en, 16'h0001);
    endtask : trip

    initial begin
        ref_clk = 1'b0; nrst = 1'b0; serial_mode = 1'b0; duty_pin = 8'h00;
        hidx = 0; hall = 3'h1; cmp = 4'h0; free_start = 1'b0;
        n_mismatch = 0; tests_run = 0;
        tick(8);
        nrst = 1'b1;
        tick(2);
        // reset values, read/write duty register, unmapped read
        rd(hpdc_pkg::ADDR_CONTROL, d); check("control", d, hpdc_pkg::CTRL_RESET);
        rd(hpdc_pkg::ADDR_DUTY, d); check("duty reset", d, hpdc_pkg::DUTY_RESET);
        host.write_reg(hpdc_pkg::ADDR_DUTY, 8'hA5);
        rd(hpdc_pkg::ADDR_DUTY, d); check("duty back", d, 16'h00A5);
        rd(8'h7F, d); check("unmapped", d, 16'h0000);
        // pin source until the select bit is set in serial mode
        duty_pin = 8'h80; serial_mode = 1'b1; tick(4);
        check("pin duty", duty_out, 16'h0080);
        host.write_reg(hpdc_pkg::ADDR_CONTROL, 8'h01);
        foreach (duty_tab[i]) begin
            host.write_reg(hpdc_pkg::ADDR_DUTY, duty_tab[i]);
            tick(4);
            check("reg duty", duty_out, duty_tab[i]);
            pwm_high(n);
            check("pwm width", n[15:0], duty_tab[i]);
        end
        serial_mode = 1'b0; tick(4);
        check("pin outside serial", duty_out, 16'h0080);
        serial_mode = 1'b1;
        // every range code, period and speed toggle
        for (int r = 0; r < 4; r++) begin
            host.write_reg(hpdc_pkg::ADDR_CONTROL, {5'h00, r[1:0], 1'b1});
            hall_step(); tick(200); s = speed; hall_step(); tick(2);
            check("speed toggle", speed, {15'h0000, ~s});
            period_rd(v);
            check("period", near(v, (r == 0) ? 16'h00C8 : (r == 1) ? 16'h0190 : 16'h0032),
                16'h0001);
        end
        // high read freezes, low read releases
        host.write_reg(hpdc_pkg::ADDR_CONTROL, 8'h01);
        hall_step(); tick(100); hall_step(); tick(2);
        rd(hpdc_pkg::ADDR_PER_HIGH, v[15:8]);
        s = speed; hall_step(); tick(2);
        check("speed frozen", speed, {15'h0000, ~s});
        tick(50); hall_step(); tick(2);
        rd(hpdc_pkg::ADDR_PER_LOW, v[7:0]);
        check("frozen period", near(v, 16'h0064), 16'h0001);
        hall_step(); tick(70); hall_step(); tick(2); period_rd(v);
        check("resumed period", near(v, 16'h0046), 16'h0001);
        // saturation at twice system clock
        host.write_reg(hpdc_pkg::ADDR_CONTROL, 8'h03);
        hall_step(); tick(33000); hall_step(); tick(2); period_rd(v);
        check("saturated", v, hpdc_pkg::PERIOD_MAX);
        // cycle limiting forces minimum duty
        host.write_reg(hpdc_pkg::ADDR_DUTY, 8'hFF);
        cmp.cycle = 1'b1; tick(3);
        check("cycle limit", duty_out, hpdc_pkg::DUTY_MIN);
        cmp.cycle = 1'b0; tick(3);
        check("limit gone", duty_out, 16'h00FF);
        // over torque lowers the ceiling, recovery restores it
        cmp.over_torque = 1'b1; tick(780);
        check("torque lowered", {15'h0000, duty_out < 8'hFE}, 16'h0001);
        cmp.over_torque = 1'b0; tick(1300);
        check("torque recovered", duty_out, 16'h00FF);
        // short pulses below the count do not trip; under 255 cycles touches two periods at most
        cmp.short_c = 1'b1; tick(200); cmp.short_c = 1'b0; tick(600);
        check("no short trip", drive_en, 16'h0001);
        trip(0, 785);
        trip(2, 4100);
        give_verdict();
    end
endmodule : hall_period_duty_control_tb_top
